// ===== hw/mii_isolate_pkg.sv
// constants for the isolate and indicator mode control of a 10/100 transceiver
// assumes one 250 MHz clock, a synchronous active-low reset and a management bus sampled on clk
// Overview of operation
// R1: isolate mode is entered when control bit ten is set or when the strapped address caught at reset is zero.
// R2: writing address zero into the phy control register does not isolate the device.
// R3: while isolated, transmit data and transmit enable from the mac are ignored.
// R4: while isolated, all mac-side outputs are released to high impedance.
// R5: while isolated, management reads and writes to this device are still answered as usual.
// R6: while isolated, the line side sends no packet data but keeps sending idles or link pulses.
// R7: negotiation, parallel detection and receive link keep running while isolated.
// R8: software picks the indicator mode through bits six and five of the phy control register.
// R9: with bit five set, link shows good link, speed shows 100 Mb/s and the third shows activity.
// R10: in modes two and three, link is on for good link and blinks during any activity.
// R11: in mode two, the activity/collision indicator shows collision.
// R12: in mode three, the activity/collision indicator shows full duplex.
// R13: leaving isolate mode restores the mac side without reset or renegotiation.
package mii_isolate_pkg;
    localparam logic [4:0]  BASIC_CTRL_ADDR  = 5'h00;
    localparam logic [4:0]  PHY_CTRL_ADDR    = 5'h19;
    localparam int          ISOLATE_BIT      = 10;
    localparam int          MODE_SEL_LSB     = 5;
    localparam int          MODE_SEL_MSB     = 6;
    localparam int          PHYAD_MSB        = 4;
    localparam logic [15:0] BASIC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] PHY_CTRL_RESET   = 16'h0020;
    localparam logic [15:0] SR_IDLE          = 16'hffff;
    localparam logic [4:0]  PHYAD_ZERO     = 5'h00;
    localparam logic [1:0]  FRAME_START    = 2'h1;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [4:0]  HDR_LAST       = 5'h0b;
    localparam logic [4:0]  RD_BITS        = 5'h10;
    localparam logic [4:0]  WR_LAST        = 5'h11;
    localparam logic [1:0]  MODE_COLLISION = 2'h0;
    localparam logic [1:0]  MODE_DUPLEX    = 2'h2;
    localparam int          CLK_MHZ        = 250;
    localparam int          BLINK_TIME_US  = 50000;
    localparam int          BLINK_CYCLES   = BLINK_TIME_US * CLK_MHZ;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_HDR  = 6'b000010,
        ST_TA   = 6'b000100,
        ST_RD   = 6'b001000,
        ST_WR   = 6'b010000,
        ST_SKIP = 6'b100000
    } mdio_state_t;
endpackage

// ===== hw/led_status_if.sv
// link status and indicator mode passed from the control core to the indicator driver
// assumes both ends share clk
`timescale 1ns/1ps
interface led_status_if;
    logic [1:0] mode;
    logic       link_good;
    logic       speed_100;
    logic       activity;
    logic       collision;
    logic       full_duplex;
    modport ctrl (output mode, link_good, speed_100, activity, collision, full_duplex);
    modport disp (input  mode, link_good, speed_100, activity, collision, full_duplex);
endinterface // led_status_if

// ===== hw/led_indicator.sv
// indicator driver: three registered indicator levels from status and mode
// assumes status levels synchronous to clk; polarity inversion is outside
`timescale 1ns/1ps
module led_indicator #(
    parameter int BLINK_CYCLES = mii_isolate_pkg::BLINK_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   resetn,
    led_status_if.disp  st,
    output logic        link_indicator,
    output logic        speed_indicator,
    output logic        activity_collision_indicator
);
    import mii_isolate_pkg::*;

    if (BLINK_CYCLES < 2) begin : g_bad_blink
        $error("BLINK_CYCLES must be at least 2");
    end

    logic [31:0] blink_cnt_q;
    logic        blink_q;
    wire         blink_wrap = (blink_cnt_q == 32'(BLINK_CYCLES - 1));
    wire         mode_one   = st.mode[0];
    wire         mode_col   = (st.mode == MODE_COLLISION);

    ////////////////////////////////////////////////////////////////////////
    // free blink phase; only looked at while activity is present
    always_ff @(posedge clk) begin
        if (!resetn) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= 1'b0;
        end else begin
            blink_cnt_q <= blink_wrap ? 32'h0 : blink_cnt_q + 32'h1;
            blink_q     <= blink_wrap ? ~blink_q : blink_q;
        end
    end

    // R9 mode one plain link; R10 blink on activity otherwise
    wire link_d = mode_one ? st.link_good
                           : (st.link_good & (~st.activity | blink_q));
    // R11 collision, R12 duplex, R9 activity
    wire actcol_d = mode_one ? st.activity
                             : (mode_col ? st.collision : st.full_duplex);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            link_indicator               <= 1'b0;
            speed_indicator              <= 1'b0;
            activity_collision_indicator <= 1'b0;
        end else begin
            link_indicator               <= link_d;
            // R9 speed independent of mode
            speed_indicator              <= st.speed_100;
            activity_collision_indicator <= actcol_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_mode_one_link: assert property (st.mode[0] |=> link_indicator == $past(st.link_good)) // R9
        else $error("mode one link indicator wrong");
    a_mode_two_col: assert property (st.mode == MODE_COLLISION |=> // R11
        activity_collision_indicator == $past(st.collision))
        else $error("mode two collision indicator wrong");
    a_mode_three_dup: assert property (st.mode == MODE_DUPLEX |=> // R12
        activity_collision_indicator == $past(st.full_duplex))
        else $error("mode three duplex indicator wrong");
    a_link_off_nolink: assert property (!st.link_good |=> !link_indicator) // R10
        else $error("link indicator on without link");
endmodule // led_indicator

// ===== hw/mii_isolate_led_mode.sv
// isolate control, management register slave and indicator mode selection
// assumes mdc and mdio are already synchronous to clk and mdc is much slower than clk;
// the mii pin drivers combine each value with mii_oe outside this block
`timescale 1ns/1ps
module mii_isolate_led_mode #(
    parameter int BLINK_CYCLES = mii_isolate_pkg::BLINK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [4:0] phyad_strap,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic [3:0] txd,
    input  wire logic       tx_en,
    output logic [3:0]      pcs_txd,
    output logic            pcs_tx_en,
    input  wire logic       core_tx_clk,
    input  wire logic       core_rx_clk,
    input  wire logic       core_rx_dv,
    input  wire logic       core_rx_er,
    input  wire logic [3:0] core_rxd,
    input  wire logic       core_col,
    input  wire logic       core_crs,
    output logic            tx_clk,
    output logic            rx_clk,
    output logic            rx_dv,
    output logic            rx_er,
    output logic [3:0]      rxd,
    output logic            col,
    output logic            crs,
    output logic            mii_oe,
    input  wire logic       link_good,
    input  wire logic       speed_100,
    input  wire logic       full_duplex,
    output logic            isolated,
    output logic            link_indicator,
    output logic            speed_indicator,
    output logic            activity_collision_indicator
);
    import mii_isolate_pkg::*;

    function automatic logic [15:0] reg_read(input logic [4:0]  addr,
                                             input logic [15:0] ctrl,
                                             input logic [15:0] phyctl);
        logic [15:0] v;
        v = 16'h0000;
        if (addr == BASIC_CTRL_ADDR) begin
            v = ctrl;
        end else if (addr == PHY_CTRL_ADDR) begin
            v = phyctl;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control registers and strap capture
    logic [15:0] basic_mode_control_q;
    logic [15:0] phy_control_reg_q;
    logic        strap_taken_q;
    logic        strap_zero_q;
    logic        wr_en;
    logic [15:0] wr_data;
    logic [4:0]  regad_q;

    // R1 strap zero or control bit isolates; R2 written address never counts
    wire isolate = basic_mode_control_q[ISOLATE_BIT] | strap_zero_q;
    assign isolated = isolate;
    // mac side stays shut until the strap is judged, so a zero strap never glitches it open
    wire mac_open = ~isolate & strap_taken_q;

    // strap sampled on the first edge after release, never under reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            strap_taken_q <= 1'b0;
            strap_zero_q  <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            strap_zero_q  <= (phyad_strap == PHYAD_ZERO);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            basic_mode_control_q <= BASIC_CTRL_RESET;
            phy_control_reg_q    <= PHY_CTRL_RESET;
        end else if (!strap_taken_q) begin
            phy_control_reg_q[PHYAD_MSB:0] <= phyad_strap;
        end else if (wr_en && regad_q == BASIC_CTRL_ADDR) begin
            basic_mode_control_q <= wr_data;
        end else if (wr_en && regad_q == PHY_CTRL_ADDR) begin
            // R2 address field stored and used to match frames, never to isolate
            phy_control_reg_q <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // management serial slave, fully independent of isolate
    mdio_state_t state_q, state_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] sr_q, sr_d;
    logic        mdc_q;
    logic        out_d, oe_d;
    logic [4:0]  regad_d;

    wire         mdc_rise  = mdc & ~mdc_q;
    wire [11:0]  hdr_w     = {sr_q[10:0], mdio_in};
    wire         hdr_match = (hdr_w[9:5] == phy_control_reg_q[PHYAD_MSB:0]);
    wire         is_read   = (hdr_w[11:10] == OP_READ);
    wire         is_write  = (hdr_w[11:10] == OP_WRITE);
    wire         hdr_done  = (state_q == ST_HDR) && mdc_rise && (cnt_q == HDR_LAST);
    wire [15:0]  rd_word   = reg_read(regad_q, basic_mode_control_q, phy_control_reg_q);
    wire [4:0]   cnt_inc   = cnt_q + 5'h01;

    assign wr_data = {sr_q[14:0], mdio_in};
    assign wr_en   = (state_q == ST_WR) && mdc_rise && (cnt_q == WR_LAST);

    // R5 transactions decoded the same whatever the isolate state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sr_d    = sr_q;
        out_d   = mdio_out;
        oe_d    = mdio_oe;
        regad_d = regad_q;
        if (mdc_rise) begin
            sr_d  = {sr_q[14:0], mdio_in};
            cnt_d = cnt_inc;
            unique case (state_q)
                ST_IDLE: begin
                    if ({sr_q[0], mdio_in} == FRAME_START) begin
                        state_d = ST_HDR;
                        cnt_d   = 5'h00;
                    end
                end
                ST_HDR: begin
                    if (cnt_q == HDR_LAST) begin
                        regad_d = hdr_w[4:0];
                        cnt_d   = 5'h00;
                        if (hdr_match && is_read) begin
                            state_d = ST_TA;
                        end else if (hdr_match && is_write) begin
                            state_d = ST_WR;
                        end else begin
                            state_d = ST_SKIP;
                        end
                    end
                end
                ST_TA: begin
                    // second turnaround bit is driven low by us
                    state_d = ST_RD;
                    cnt_d   = 5'h00;
                    sr_d    = rd_word;
                    out_d   = 1'b0;
                    oe_d    = 1'b1;
                end
                ST_RD: begin
                    sr_d  = {sr_q[14:0], 1'b0};
                    out_d = sr_q[15];
                    if (cnt_q == RD_BITS) begin
                        oe_d    = 1'b0;
                        out_d   = 1'b0;
                        state_d = ST_IDLE;
                        sr_d    = SR_IDLE;
                    end
                end
                ST_WR, ST_SKIP: begin
                    if (cnt_q == WR_LAST) begin
                        state_d = ST_IDLE;
                        sr_d    = SR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 5'h00;
            // idle ones and a high last mdc: no false start or rise after reset
            sr_q     <= SR_IDLE;
            mdc_q    <= 1'b1;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
            regad_q  <= 5'h00;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            sr_q     <= sr_d;
            mdc_q    <= mdc;
            mdio_out <= out_d;
            mdio_oe  <= oe_d;
            regad_q  <= regad_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mac side gating
    // R4 released while isolated; R13 restored on the next edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mii_oe <= 1'b0;
        end else begin
            mii_oe <= mac_open;
        end
    end

    // clocks pass straight through, only their enable is registered
    assign tx_clk = core_tx_clk;
    assign rx_clk = core_rx_clk;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd   <= 4'h0;
            col   <= 1'b0;
            crs   <= 1'b0;
        end else begin
            rx_dv <= core_rx_dv;
            rx_er <= core_rx_er;
            rxd   <= core_rxd;
            col   <= core_col;
            crs   <= core_crs;
        end
    end

    // R3 mac transmit ignored; R6 line coder idles when pcs_tx_en low
    // R13 nothing but isolate and the strap guard gate the path, so data resumes at once
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pcs_tx_en <= 1'b0;
            pcs_txd   <= 4'h0;
        end else begin
            pcs_tx_en <= tx_en & mac_open;
            pcs_txd   <= mac_open ? txd : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators; R7 link and speed come ungated by isolate
    led_status_if led_st ();

    // R8 mode field of the phy control register
    assign led_st.mode        = phy_control_reg_q[MODE_SEL_MSB:MODE_SEL_LSB];
    assign led_st.link_good   = link_good;
    assign led_st.speed_100   = speed_100;
    assign led_st.activity    = core_crs | pcs_tx_en;
    assign led_st.collision   = core_col;
    assign led_st.full_duplex = full_duplex;

    led_indicator #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_led (
        .clk                          (clk),
        .resetn                       (resetn),
        .st                           (led_st),
        .link_indicator               (link_indicator),
        .speed_indicator              (speed_indicator),
        .activity_collision_indicator (activity_collision_indicator)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_read_hdr;
        hdr_done && hdr_match && is_read;
    endsequence
    sequence s_ta_edge;
        state_q == ST_TA && mdc_rise;
    endsequence

    a_isolate_strap: assert property (strap_taken_q && strap_zero_q |-> isolated) // R1
        else $error("strap zero did not isolate");
    a_isolate_bit: assert property (isolated == // R1
        (basic_mode_control_q[ISOLATE_BIT] || strap_zero_q))
        else $error("isolate not tied to its causes");
    a_phyad_write: assert property (wr_en && regad_q == PHY_CTRL_ADDR && !strap_zero_q // R2
        && !basic_mode_control_q[ISOLATE_BIT] |=> !isolated)
        else $error("address write isolated the device");
    a_tx_gated: assert property (isolated |=> !pcs_tx_en && pcs_txd == 4'h0) // R3
        else $error("transmit data passed while isolated");
    a_mii_release: assert property (isolated |=> !mii_oe) // R4
        else $error("mac outputs driven while isolated");
    a_strap_guard: assert property (!strap_taken_q |=> !mii_oe && !pcs_tx_en) // R1
        else $error("mac side opened before strap judged");
    a_read_ta: assert property (s_read_hdr |=> state_q == ST_TA && !mdio_oe) // R5
        else $error("read header not taken");
    a_read_drive: assert property (s_ta_edge |=> mdio_oe && !mdio_out && state_q == ST_RD) // R5
        else $error("turnaround not driven");
    a_resume: assert property ($fell(isolated) |=> mii_oe ##0 // R13
        (pcs_tx_en == $past(tx_en)))
        else $error("mac side not restored");
endmodule // mii_isolate_led_mode

// ===== sim/mgmt_station.sv
// management station model: clocks frames out on mdc and mdio, reads answers back
// assumes the device samples mdc on clk; the mdio line carries a pull-up
`timescale 1ns/1ps
module mgmt_station (
    input  wire logic clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    output logic      mdc,
    output logic      mdio_in
);
    logic drv;
    logic bit_q;

    // released line floats to the pull-up level, never to the last driven bit
    assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_q : 1'b1);

    initial begin
        mdc   = 1'b0;
        drv   = 1'b0;
        bit_q = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one mdc period of 8 clocks; sample late in the high phase
    task automatic clk_bit(input logic d, input logic en, output logic s);
        @(negedge clk);
        mdc   = 1'b0;
        drv   = en;
        bit_q = d;
        repeat (3) @(negedge clk);
        mdc = 1'b1;
        repeat (4) @(negedge clk);
        s = mdio_in;
    endtask

    // read: 18 released bits after header; write: turnaround 1,0 then data
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q, output logic seen);
        logic [17:0] hdr;
        logic [17:0] wbits;
        logic        s;
        hdr   = {4'hf, 2'h1, (rd ? 2'h2 : 2'h1), pa, ra};
        wbits = {2'h2, wd};
        q     = 16'h0000;
        seen  = 1'b0;
        for (int i = 17; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
        for (int i = 0; i < 18; i++) begin
            if (rd) begin
                clk_bit(1'b1, 1'b0, s);
                if (i >= 1 && i <= 16) begin
                    q    = {q[14:0], s};
                    seen = seen | mdio_oe;
                end
            end else begin
                clk_bit(wbits[17-i], 1'b1, s);
            end
        end
        drv = 1'b0;
    endtask
endmodule // mgmt_station

// ===== sim/mii_isolate_led_mode_tb_top.sv
// self-checking bench: isolate control, register access and indicator modes
// assumes the device answers management frames on mdc rises sampled on clk
`timescale 1ns/1ps
module mii_isolate_led_mode_tb_top;
    localparam int BLINK = 4;
    logic clk, resetn, mdc, mdio_in, mdio_out, mdio_oe, tx_en, pcs_tx_en, seen;
    logic core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er, core_col, core_crs;
    logic tx_clk, rx_clk, rx_dv, rx_er, col, crs, mii_oe, isolated;
    logic link_good, speed_100, full_duplex, link_indicator, speed_indicator;
    logic activity_collision_indicator;
    logic [4:0]  phyad_strap;
    logic [3:0]  txd, pcs_txd, core_rxd, rxd;
    logic [15:0] q;
    logic [1:0]  md [4];
    int          n_mismatch, tests_run, cyc, cnt;

    mii_isolate_led_mode #(.BLINK_CYCLES(BLINK)) dut_u (
        .clk(clk), .resetn(resetn), .phyad_strap(phyad_strap), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .txd(txd),
        .tx_en(tx_en), .pcs_txd(pcs_txd), .pcs_tx_en(pcs_tx_en),
        .core_tx_clk(core_tx_clk), .core_rx_clk(core_rx_clk), .core_rx_dv(core_rx_dv),
        .core_rx_er(core_rx_er), .core_rxd(core_rxd), .core_col(core_col),
        .core_crs(core_crs), .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_dv(rx_dv),
        .rx_er(rx_er), .rxd(rxd), .col(col), .crs(crs), .mii_oe(mii_oe),
        .link_good(link_good), .speed_100(speed_100), .full_duplex(full_duplex),
        .isolated(isolated), .link_indicator(link_indicator),
        .speed_indicator(speed_indicator),
        .activity_collision_indicator(activity_collision_indicator));

    mgmt_station station_u (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
                            .mdc(mdc), .mdio_in(mdio_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] v, input logic [15:0] e);
        tests_run++;
        if (v !== e) begin
            n_mismatch++;
            $display("wrong value at %0t ns: got %h expected %h", $time, v, e);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
        station_u.frame(1'b1, pa, ra, 16'h0000, q, seen);
    endtask

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        station_u.frame(1'b0, pa, ra, d, q, seen);
    endtask

    task automatic do_reset(input logic [4:0] strap);
        @(negedge clk);
        resetn      = 1'b0;
        phyad_strap = strap;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // hang guard: 14 frames of about 300 clocks each fit well below this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, tx_en, core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er} = 6'h00;
        {core_col, core_crs, link_good, speed_100, full_duplex} = 5'h00;
        {txd, core_rxd} = 8'h00;
        phyad_strap = 5'h03;
        n_mismatch = 0;
        tests_run = 0;
        cyc = 0;
        md = '{2'h1, 2'h0, 2'h2, 2'h3};
        do_reset(5'h03);
        check(isolated, 1'b0);
        check(mii_oe, 1'b1);
        rd(5'h03, 5'h00);
        check(q, 16'h0000);
        rd(5'h03, 5'h19);
        check(q, 16'h0023);
        rd(5'h03, 5'h05);
        check(q, 16'h0000);
        rd(5'h07, 5'h00);
        check(seen, 1'b0);
        tx_en = 1'b1;
        txd = 4'ha;
        core_rx_dv = 1'b1;
        core_rxd = 4'h6;
        {core_tx_clk, core_rx_clk, core_rx_er, core_col, core_crs} = 5'h1f;
        repeat (2) @(negedge clk);
        check({pcs_tx_en, pcs_txd, rx_dv, rxd, tx_clk}, {1'b1, 4'ha, 1'b1, 4'h6, 1'b1});
        check({rx_clk, rx_er, col, crs}, 4'hf);
        $display("test reset and normal path done");

        wr(5'h03, 5'h00, 16'h0400);
        check({isolated, mii_oe}, 2'h2);
        check({pcs_tx_en, pcs_txd}, 5'h00);
        check({rx_dv, crs, mii_oe}, 3'h6);
        rd(5'h03, 5'h00);
        check(q, 16'h0400);
        check(seen, 1'b1);
        wr(5'h03, 5'h00, 16'h0000);
        repeat (2) @(negedge clk);
        check({isolated, mii_oe, pcs_tx_en, pcs_txd}, {3'h3, 4'ha} & 7'h3f);
        $display("test isolate by control bit done");

        // address zero written by software must not isolate
        wr(5'h03, 5'h19, 16'h0000);
        repeat (2) @(negedge clk);
        check({isolated, mii_oe}, 2'h1);
        rd(5'h00, 5'h19);
        check(q, 16'h0000);
        $display("test software address zero done");

        tx_en = 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(5'h00, 5'h19, {9'h000, md[k], 5'h00});
            {link_good, speed_100, full_duplex, core_col, core_crs} = {1'b1, md[k][1], 3'h6};
            repeat (3) @(negedge clk);
            check({link_indicator, speed_indicator}, {1'b1, md[k][1]});
            check(activity_collision_indicator, !md[k][0]);
            {full_duplex, core_col, core_crs} = 3'h1;
            repeat (3) @(negedge clk);
            check(activity_collision_indicator, md[k][0]);
            cnt = 0;
            for (int j = 0; j < 16; j++) begin
                @(negedge clk);
                cnt += int'(link_indicator === 1'b1);
            end
            check(md[k][0] ? cnt == 16 : (cnt > 0 && cnt < 16), 1'b1);
        end
        $display("test indicator modes done");

        core_crs = 1'b0;
        tx_en = 1'b1;
        do_reset(5'h00);
        check({isolated, mii_oe, pcs_tx_en}, 3'h4);
        rd(5'h00, 5'h19);
        check(q, 16'h0020);
        check(link_indicator, 1'b1);
        $display("test strapped address zero done");
        end_sim();
    end
endmodule // mii_isolate_led_mode_tb_top
